// >>> devcap_pkg.sv
package devcap_pkg;
  localparam logic [7:0]  DEVCAP_OFFSET    = 8'h94;
  localparam logic [31:0] DEVCAP_RESET     = 32'h00000D82;
  localparam int          SCALE_LSB        = 26;
  localparam int          VALUE_LSB        = 18;
  localparam int          DEEP_LSB         = 9;
  localparam int          LIGHT_LSB        = 6;
  localparam int          GCTL_DEEP_LSB    = 13;
  localparam int          GCTL_LIGHT_LSB   = 16;
  localparam int          MSG_SCALE_LSB    = 8;
  localparam logic [2:0]  LATENCY_RESET    = 3'h6;
  localparam logic [1:0]  SCALE_RESET      = 2'h0;
  localparam logic [7:0]  VALUE_RESET      = 8'h00;
  localparam logic [1:0]  GHOST_FUNCS      = 2'h0;
  localparam logic [2:0]  MAX_PAYLOAD_512  = 3'h2;
endpackage

// >>> device_capabilities_reg.sv
module device_capabilities_reg (
  input  wire logic        CORE_CLK,
  input  wire logic        ARST_N,
  input  wire logic        CFG_RD,
  input  wire logic        CFG_WR,
  input  wire logic [7:0]  CFG_ADDR,
  input  wire logic [31:0] CFG_WDATA,
  output logic             CFG_RVALID,
  output logic      [31:0] CFG_RDATA,
  input  wire logic        SLOT_POWER_MSG,
  input  wire logic [9:0]  SLOT_POWER_PAYLOAD,
  input  wire logic        GCTL_WR,
  input  wire logic [31:0] GCTL_WDATA,
  input  wire logic [2:0]  PHY_DEEP_EXIT,
  input  wire logic [2:0]  PHY_LIGHT_EXIT,
  output logic      [31:0] DEVICE_CAPABILITIES
);
  logic [1:0]  captured_power_scale_q;
  logic [7:0]  captured_power_value_q;
  logic [2:0]  deep_idle_exit_latency_q;
  logic [2:0]  light_idle_exit_latency_q;
  logic        rvalid_q;
  logic [31:0] rdata_q;
  logic [31:0] capabilities;
  logic        addr_hit;
  logic [2:0]  deep_idle_latency_setting;
  logic [2:0]  light_idle_latency_setting;
  logic [2:0]  deep_d;
  logic [2:0]  light_d;
  logic [1:0]  word_scale;
  logic [7:0]  word_value;
  logic [2:0]  word_deep;
  logic [2:0]  word_light;

  // floor at the phy exit time; a smaller request is raised, not dropped
  function automatic logic [2:0] floor_at(input logic [2:0] req, input logic [2:0] lim);
    floor_at = (req < lim) ? lim : req;
  endfunction

  assign deep_idle_latency_setting  = GCTL_WDATA[devcap_pkg::GCTL_DEEP_LSB +: 3];
  assign light_idle_latency_setting = GCTL_WDATA[devcap_pkg::GCTL_LIGHT_LSB +: 3];
  assign deep_d  = floor_at(deep_idle_latency_setting, PHY_DEEP_EXIT);
  assign light_d = floor_at(light_idle_latency_setting, PHY_LIGHT_EXIT);
  assign addr_hit = (CFG_ADDR == devcap_pkg::DEVCAP_OFFSET);
  assign word_scale = capabilities[devcap_pkg::SCALE_LSB +: 2];
  assign word_value = capabilities[devcap_pkg::VALUE_LSB +: 8];
  assign word_deep  = capabilities[devcap_pkg::DEEP_LSB +: 3];
  assign word_light = capabilities[devcap_pkg::LIGHT_LSB +: 3];

  // reserved, indicator, tag and ghost bits are constant zero
  assign capabilities = {4'h0,
                         captured_power_scale_q,
                         captured_power_value_q,
                         3'h0,
                         1'b0, 1'b0, 1'b0,
                         deep_idle_exit_latency_q,
                         light_idle_exit_latency_q,
                         1'b0,
                         devcap_pkg::GHOST_FUNCS,
                         devcap_pkg::MAX_PAYLOAD_512};

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      captured_power_scale_q <= devcap_pkg::SCALE_RESET;
      captured_power_value_q <= devcap_pkg::VALUE_RESET;
    end else if (SLOT_POWER_MSG) begin
      captured_power_scale_q <= SLOT_POWER_PAYLOAD[devcap_pkg::MSG_SCALE_LSB +: 2];
      captured_power_value_q <= SLOT_POWER_PAYLOAD[7:0];
    end
  end

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      deep_idle_exit_latency_q  <= devcap_pkg::LATENCY_RESET;
      light_idle_exit_latency_q <= devcap_pkg::LATENCY_RESET;
    end else if (GCTL_WR) begin
      deep_idle_exit_latency_q  <= deep_d;
      light_idle_exit_latency_q <= light_d;
    end
  end

  // config writes never reach the word; unmapped reads return zero
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h00000000;
    end else begin
      rvalid_q <= CFG_RD;
      rdata_q  <= (CFG_RD && addr_hit) ? capabilities : 32'h00000000;
    end
  end

  assign CFG_RVALID          = rvalid_q;
  assign CFG_RDATA           = rdata_q;
  assign DEVICE_CAPABILITIES = capabilities;

  a_read_timing: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    CFG_RD |=> CFG_RVALID) else $error("read answer missing");
  a_read_data: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    (CFG_RD && addr_hit) |=> (CFG_RDATA == $past(capabilities))) else $error("read data wrong");
  a_write_ignored: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    (CFG_WR && !SLOT_POWER_MSG && !GCTL_WR) |=> $stable(capabilities))
    else $error("config write changed word");
  a_reserved_zero: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    capabilities[31:28] == 4'h0 && capabilities[17:12] == 6'h00) else $error("reserved bits set");
  a_scale_capture: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    SLOT_POWER_MSG |=> capabilities[27:26] == $past(SLOT_POWER_PAYLOAD[9:8]))
    else $error("scale not captured");
  a_value_capture: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    SLOT_POWER_MSG |=> capabilities[25:18] == $past(SLOT_POWER_PAYLOAD[7:0]))
    else $error("value not captured");
  a_power_hold: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    !SLOT_POWER_MSG |=> $stable(capabilities[27:18])) else $error("power fields drifted");
  a_deep_floor: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    GCTL_WR |=> capabilities[11:9] >= $past(PHY_DEEP_EXIT)
      && capabilities[11:9] >= $past(deep_idle_latency_setting))
    else $error("deep latency below floor");
  a_light_floor: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    GCTL_WR |=> capabilities[8:6] >= $past(PHY_LIGHT_EXIT)
      && capabilities[8:6] >= $past(light_idle_latency_setting))
    else $error("light latency below floor");
  a_const_low: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    capabilities[5:0] == 6'h02) else $error("constant low field wrong");

  // read answer and message capture are two-step behaviours
  sequence s_read_hit;
    CFG_RD && addr_hit;
  endsequence
  sequence s_word_answer;
    CFG_RVALID && (CFG_RDATA == $past(capabilities));
  endsequence
  sequence s_power_msg;
    SLOT_POWER_MSG;
  endsequence
  sequence s_power_landed;
    {word_scale, word_value} == $past(SLOT_POWER_PAYLOAD);
  endsequence

  a_read_word: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    s_read_hit |=> s_word_answer) else $error("read hit answer wrong");
  a_read_quiet: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    !CFG_RD |=> !CFG_RVALID && CFG_RDATA == 32'h00000000) else $error("idle read output set");
  a_read_miss: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    (CFG_RD && !addr_hit) |=> CFG_RDATA == 32'h00000000) else $error("unmapped read not zero");
  a_power_pair: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    s_power_msg |=> s_power_landed) else $error("power fields not captured");
  a_deep_copy: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    (GCTL_WR && deep_idle_latency_setting >= PHY_DEEP_EXIT) |=>
      word_deep == $past(deep_idle_latency_setting)) else $error("deep latency not copied");
  a_deep_raise: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    (GCTL_WR && deep_idle_latency_setting < PHY_DEEP_EXIT) |=>
      word_deep == $past(PHY_DEEP_EXIT)) else $error("deep latency not raised");
  a_light_copy: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    (GCTL_WR && light_idle_latency_setting >= PHY_LIGHT_EXIT) |=>
      word_light == $past(light_idle_latency_setting)) else $error("light latency not copied");
  a_light_raise: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    (GCTL_WR && light_idle_latency_setting < PHY_LIGHT_EXIT) |=>
      word_light == $past(PHY_LIGHT_EXIT)) else $error("light latency not raised");
  a_deep_hold: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    !GCTL_WR |=> $stable(word_deep)) else $error("deep latency drifted");
  a_light_hold: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    !GCTL_WR |=> $stable(word_light)) else $error("light latency drifted");
  a_mid_zero: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    capabilities[17:15] == 3'h0) else $error("middle reserved bits set");
  a_lamps_zero: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    capabilities[14:12] == 3'h0) else $error("indicator bits set");
  a_wide_tag_zero: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    capabilities[5] == 1'b0) else $error("wide tag bit set");
  a_ghost_zero: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    capabilities[4:3] == devcap_pkg::GHOST_FUNCS) else $error("ghost function field wrong");
  a_max_payload: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    capabilities[2:0] == devcap_pkg::MAX_PAYLOAD_512) else $error("max payload field wrong");
endmodule

// >>> host_model.sv
module host_model (
  input  wire logic       clk,
  output logic            msg,
  output logic      [9:0] payload
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    msg = 1'h0;
    payload = 10'h000;
  end
  // idle payload shows inverted value so a stale copy is never trusted
  task automatic send(input logic [9:0] p);
    @(negedge clk);
    msg = 1'h1;
    payload = p;
    @(negedge clk);
    msg = 1'h0;
    payload = ~p;
  endtask
endmodule

// >>> tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, arst_n, rd, wr, gwr, rv, msg;
  logic [7:0]  addr;
  logic [31:0] gd, rdat, word;
  logic [2:0]  pd, pl;
  logic [9:0]  pay;
  int          n_errors, total_checks, cyc;
  device_capabilities_reg dut (.CORE_CLK(clk), .ARST_N(arst_n), .CFG_RD(rd), .CFG_WR(wr),
    .CFG_ADDR(addr), .CFG_WDATA(gd), .CFG_RVALID(rv), .CFG_RDATA(rdat),
    .SLOT_POWER_MSG(msg), .SLOT_POWER_PAYLOAD(pay), .GCTL_WR(gwr), .GCTL_WDATA(gd),
    .PHY_DEEP_EXIT(pd), .PHY_LIGHT_EXIT(pl), .DEVICE_CAPABILITIES(word));
  host_model host (.clk(clk), .msg(msg), .payload(pay));
  initial begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end
  // generous ceiling: the sequence needs under a hundred cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      report_and_stop();
    end
  end
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    @(negedge clk);
    rd = 1'h1;
    addr = a;
    @(negedge clk);
    rd = 1'h0;
    chk("rvalid", {31'h0, rv}, 32'h1);
    chk("rdata", rdat, e);
    @(negedge clk);
    chk("rvalid idle", {31'h0, rv}, 32'h0);
    chk("rdata idle", rdat, 32'h0);
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    {arst_n, rd, wr, gwr, addr, gd, pd, pl} = '0;
    repeat (10) @(negedge clk);
    arst_n = 1'h1;
    rd_chk(8'h94, 32'h00000D82);
    gd = 32'hFFFFFFFF;
    wr = 1'h1;
    @(negedge clk);
    wr = 1'h0;
    rd_chk(8'h94, 32'h00000D82);
    rd_chk(8'h98, 32'h0);
    for (int s = 0; s < 4; s++) begin
      host.send({s[1:0], 8'hA5});
      chk("word", word, {4'h0, s[1:0], 8'hA5, 18'h00D82});
    end
    repeat (5) @(negedge clk);
    chk("hold", word, 32'h0E940D82);
    // deep setting below its floor, light setting above
    gd = 32'h00072000;
    pd = 3'h2;
    pl = 3'h4;
    gwr = 1'h1;
    @(negedge clk);
    gwr = 1'h0;
    chk("lat", word, {4'h0, 2'h3, 8'hA5, 3'h0, 3'h0, 3'h2, 3'h7, 6'h02});
    // deep setting above its floor, light setting below
    @(negedge clk);
    gd = 32'h0001E000;
    gwr = 1'h1;
    @(negedge clk);
    gwr = 1'h0;
    chk("lat2", word, {4'h0, 2'h3, 8'hA5, 3'h0, 3'h0, 3'h7, 3'h4, 6'h02});
    rd_chk(8'h94, 32'h0E940F02);
    arst_n = 1'h0;
    @(negedge clk);
    arst_n = 1'h1;
    chk("reset", word, 32'h00000D82);
    rd_chk(8'h94, 32'h00000D82);
    report_and_stop();
  end
endmodule
